// [design/vacuum_pump_run_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
module vacuum_pump_run_supervisor
   import pump_sup_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int DEB_CYCLES = DEB_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_btn_onoff,
   input wire logic i_panel_low_sw,
   input wire logic i_remote_start,
   input wire logic i_remote_low,
   input wire logic i_interlock_ok,
   input wire logic i_power_good,
   input wire logic i_stator_short,
   input wire logic [7:0] i_pump_temp_c,
   input wire logic i_ctrl_overtemp,
   input wire logic [9:0] i_power_w,
   input wire logic [6:0] i_rotor_pct,
   output logic o_drive_en,
   output logic o_max_power,
   output logic [6:0] o_freq_pct,
   output logic o_normal_speed,
   output logic o_low_speed_ind,
   output logic o_overload,
   output logic o_fault,
   output logic o_forepump,
   output logic o_fan,
   output logic o_vent
);
   localparam int TW = $clog2(TICK_CYCLES);
   localparam int DW = $clog2(DEB_CYCLES);

   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hff) ? v : v + 8'h01;
   endfunction

   function automatic logic [6:0] lock_freq(input logic [6:0] rotor);
      lock_freq = (rotor > F_START) ? rotor : F_START;
   endfunction

   // Time base and button debounce
   logic [TW-1:0] tick_cnt_ff, nxt_tick_cnt;
   logic tick_ff, nxt_tick;
   logic [DW-1:0] deb_cnt_ff, nxt_deb_cnt;
   logic btn_stable_ff, nxt_btn_stable;
   logic press_ff, nxt_press;

   always_comb begin
      nxt_tick_cnt = tick_cnt_ff + 1'b1;
      nxt_tick = 1'b0;
      if (tick_cnt_ff == TW'(TICK_CYCLES - 1)) begin
         nxt_tick_cnt = '0;
         nxt_tick = 1'b1;
      end
      nxt_btn_stable = btn_stable_ff;
      nxt_press = 1'b0;
      nxt_deb_cnt = '0;
      if (i_btn_onoff != btn_stable_ff) begin
         nxt_deb_cnt = deb_cnt_ff + 1'b1;
         if (deb_cnt_ff == DW'(DEB_CYCLES - 1)) begin
            nxt_deb_cnt = '0;
            nxt_btn_stable = i_btn_onoff;
            nxt_press = i_btn_onoff;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
         deb_cnt_ff <= '0;
         btn_stable_ff <= 1'b0;
         press_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
         deb_cnt_ff <= nxt_deb_cnt;
         btn_stable_ff <= nxt_btn_stable;
         press_ff <= nxt_press;
      end
   end

   // Sequencer state
   run_state_t st_ff, nxt_st;
   low_owner_t own_ff, nxt_own;
   logic armed_ff, nxt_armed;
   logic ack_ff, nxt_ack;
   logic [7:0] run_s_ff, nxt_run_s;
   logic [7:0] over_s_ff, nxt_over_s;
   logic [7:0] vent_s_ff, nxt_vent_s;
   logic [6:0] freq_ff, nxt_freq;
   logic drive_ff, fore_ff, fan_ff, vent_ff, ovl_ff, fault_ff;
   logic normal_ff, low_ind_ff, maxp_ff;
   logic nxt_drive, nxt_fore, nxt_fan, nxt_vent, nxt_ovl, nxt_fault;
   logic nxt_normal, nxt_low_ind, nxt_maxp;
   logic [7:0] vent_dly_ff;
   logic [9:0] knee_ff;

   logic run_req, low_req, low_act, cause_now, ovl_trip, active;
   logic [9:0] excess;
   logic [6:0] cut, load_tgt, target, mode_tgt;

   always_comb begin
      run_req = armed_ff & i_remote_start & i_interlock_ok;
      nxt_own = own_ff;
      case (own_ff)
         OWN_NONE: begin
            if (i_panel_low_sw) begin
               nxt_own = OWN_PANEL;
            end else if (i_remote_low) begin
               nxt_own = OWN_REMOTE;
            end
         end
         OWN_PANEL: begin
            if (!i_panel_low_sw) begin
               nxt_own = OWN_NONE;
            end
         end
         OWN_REMOTE: begin
            if (!i_remote_low) begin
               nxt_own = OWN_NONE;
            end
         end
         default: nxt_own = OWN_NONE;
      endcase
      low_req = (own_ff != OWN_NONE);
      low_act = low_req & (run_s_ff >= T_LOW_S);
      excess = (i_power_w > knee_ff) ? (i_power_w - knee_ff) : 10'h000;
      cut = (excess[9:1] > 9'(F_NOM - F_MIN_LOAD)) ?
            (F_NOM - F_MIN_LOAD) : excess[7:1];
      load_tgt = F_NOM - cut;
      target = low_act ? F_LOW : load_tgt;
      mode_tgt = low_act ? F_LOW : F_NOM;
      active = (st_ff == S_ACC) | (st_ff == S_SYNC) |
               (st_ff == S_ACCEL) | (st_ff == S_RUN);
      cause_now = i_stator_short | (i_pump_temp_c > TEMP_MAX_C) | i_ctrl_overtemp;
      ovl_trip = cause_now;
      if (over_s_ff > T_OVER_S) begin
         ovl_trip = 1'b1;
      end
      if (st_ff != S_ACC && run_s_ff < T_START1_S && i_power_w > P_START1_W) begin
         ovl_trip = 1'b1;
      end
      if (run_s_ff >= T_START1_S && run_s_ff < 8'(T_START1_S + T_START2_S) &&
          i_power_w > P_START2_W) begin
         ovl_trip = 1'b1;
      end

      nxt_st = st_ff;
      nxt_armed = armed_ff;
      nxt_ack = ack_ff;
      nxt_freq = freq_ff;
      nxt_run_s = run_s_ff;
      nxt_over_s = over_s_ff;
      nxt_vent_s = vent_s_ff;
      if (tick_ff) begin
         nxt_run_s = sat_inc(run_s_ff);
         nxt_vent_s = sat_inc(vent_s_ff);
         if (i_power_w > P_OVER_W) begin
            nxt_over_s = sat_inc(over_s_ff);
         end
      end
      if (i_power_w <= P_OVER_W) begin
         nxt_over_s = 8'h00;
      end
      if (press_ff && st_ff != S_FAULT) begin
         nxt_armed = ~armed_ff;
      end
      case (st_ff)
         S_IDLE: begin
            nxt_run_s = 8'h00;
            nxt_over_s = 8'h00;
            if (run_req && !nxt_armed == 1'b0) begin
               nxt_st = S_ACC;
            end
         end
         S_ACC: begin
            nxt_run_s = 8'h00;
            if (tick_ff) begin
               nxt_st = S_SYNC;
               nxt_freq = lock_freq(i_rotor_pct);
            end
         end
         S_SYNC: begin
            nxt_freq = lock_freq(i_rotor_pct);
            nxt_st = S_ACCEL;
         end
         S_ACCEL: begin
            if (freq_ff >= target) begin
               nxt_st = S_RUN;
            end else if (tick_ff) begin
               nxt_freq = freq_ff + 7'h01;
            end
         end
         S_RUN: begin
            if (tick_ff && freq_ff < target) begin
               nxt_freq = freq_ff + 7'h01;
            end else if (tick_ff && freq_ff > target) begin
               nxt_freq = freq_ff - 7'h01;
            end
         end
         S_FAULT: begin
            if (press_ff && ack_ff) begin
               nxt_ack = 1'b0;
               nxt_armed = 1'b1;
               nxt_st = S_ACC;
               nxt_vent_s = 8'h00;
            end else if (press_ff && !cause_now) begin
               nxt_ack = 1'b1;
            end
         end
         S_PFAIL: begin
            nxt_run_s = 8'h00;
            nxt_over_s = 8'h00;
            if (i_power_good) begin
               nxt_st = armed_ff ? S_ACC : S_IDLE;
            end
         end
         default: nxt_st = S_IDLE;
      endcase
      if (active) begin
         nxt_vent_s = 8'h00;
         if (!run_req) begin
            nxt_st = S_IDLE;
            nxt_run_s = 8'h00;
         end
         if (ovl_trip) begin
            nxt_st = S_FAULT;
            nxt_ack = 1'b0;
            nxt_run_s = 8'h00;
         end
      end
      if (st_ff == S_IDLE && nxt_st == S_ACC) begin
         nxt_vent_s = 8'h00;
      end
      if (!i_power_good && st_ff != S_FAULT) begin
         nxt_st = S_PFAIL;
      end
      // Zero whenever drive is off, so a cut start leaves no stale preset
      if (nxt_st != S_SYNC && nxt_st != S_ACCEL && nxt_st != S_RUN) begin
         nxt_freq = 7'h00;
      end

      nxt_drive = (nxt_st == S_SYNC) | (nxt_st == S_ACCEL) | (nxt_st == S_RUN);
      nxt_maxp = (nxt_st == S_SYNC) | (nxt_st == S_ACCEL);
      nxt_fore = nxt_drive | (nxt_st == S_ACC);
      nxt_fan = nxt_fore;
      nxt_ovl = (nxt_st == S_FAULT);
      nxt_fault = (nxt_st == S_FAULT);
      nxt_normal = (nxt_st == S_RUN) & (nxt_freq == mode_tgt);
      nxt_low_ind = (nxt_st == S_RUN) & low_act;
      nxt_vent = !nxt_fore && (st_ff != S_IDLE || vent_s_ff != 8'h00) &&
                 (nxt_vent_s >= vent_dly_ff);
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st_ff <= S_IDLE;
         own_ff <= OWN_NONE;
         armed_ff <= 1'b0;
         ack_ff <= 1'b0;
         run_s_ff <= 8'h00;
         over_s_ff <= 8'h00;
         vent_s_ff <= 8'h00;
         freq_ff <= 7'h00;
         drive_ff <= 1'b0;
         maxp_ff <= 1'b0;
         fore_ff <= 1'b0;
         fan_ff <= 1'b0;
         ovl_ff <= 1'b0;
         fault_ff <= 1'b0;
         normal_ff <= 1'b0;
         low_ind_ff <= 1'b0;
         vent_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         own_ff <= nxt_own;
         armed_ff <= nxt_armed;
         ack_ff <= nxt_ack;
         run_s_ff <= nxt_run_s;
         over_s_ff <= nxt_over_s;
         vent_s_ff <= nxt_vent_s;
         freq_ff <= nxt_freq;
         drive_ff <= nxt_drive;
         maxp_ff <= nxt_maxp;
         fore_ff <= nxt_fore;
         fan_ff <= nxt_fan;
         ovl_ff <= nxt_ovl;
         fault_ff <= nxt_fault;
         normal_ff <= nxt_normal;
         low_ind_ff <= nxt_low_ind;
         vent_ff <= nxt_vent;
      end
   end

   // AHB-Lite slave, zero wait states
   logic wr_ff, nxt_wr;
   logic [7:0] waddr_ff, nxt_waddr;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [7:0] nxt_vent_dly;
   logic [9:0] nxt_knee;
   logic addr_ph;

   always_comb begin
      addr_ph = i_hsel & i_hready & i_htrans[1];
      nxt_wr = addr_ph & i_hwrite;
      nxt_waddr = i_haddr[7:0];
      nxt_rdata = 32'h0000_0000;
      if (addr_ph && !i_hwrite) begin
         case (i_haddr[7:0])
            A_VENT_DLY: nxt_rdata = {24'h000000, vent_dly_ff};
            A_LOAD_KNEE: nxt_rdata = {22'h0, knee_ff};
            A_STATUS: begin
               nxt_rdata[2:0] = st_ff;
               nxt_rdata[SB_ARMED] = armed_ff;
               nxt_rdata[SB_ACK] = ack_ff;
               nxt_rdata[SB_LOW_REQ] = low_req;
               nxt_rdata[SB_LOW_ACT] = low_act;
               nxt_rdata[SB_DRIVE] = drive_ff;
               nxt_rdata[SB_OVL] = ovl_ff;
               nxt_rdata[SB_FAULT] = fault_ff;
               nxt_rdata[SB_FORE] = fore_ff;
               nxt_rdata[SB_FAN] = fan_ff;
               nxt_rdata[SB_VENT] = vent_ff;
               nxt_rdata[SB_NORMAL] = normal_ff;
               nxt_rdata[SB_RUN_S +: 8] = run_s_ff;
            end
            A_SPEED: begin
               nxt_rdata[6:0] = freq_ff;
               nxt_rdata[SB_ROTOR +: 7] = i_rotor_pct;
               nxt_rdata[SB_POWER +: 10] = i_power_w;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
      nxt_vent_dly = vent_dly_ff;
      nxt_knee = knee_ff;
      if (wr_ff && waddr_ff == A_VENT_DLY) begin
         nxt_vent_dly = i_hwdata[7:0];
      end
      if (wr_ff && waddr_ff == A_LOAD_KNEE) begin
         nxt_knee = i_hwdata[9:0];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wr_ff <= 1'b0;
         waddr_ff <= 8'h00;
         rdata_ff <= 32'h0000_0000;
         vent_dly_ff <= VENT_DLY_RST;
         knee_ff <= LOAD_KNEE_RST;
      end else begin
         wr_ff <= nxt_wr;
         waddr_ff <= nxt_waddr;
         rdata_ff <= nxt_rdata;
         vent_dly_ff <= nxt_vent_dly;
         knee_ff <= nxt_knee;
      end
   end

   assign o_hrdata = rdata_ff;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_drive_en = drive_ff;
   assign o_max_power = maxp_ff;
   assign o_freq_pct = freq_ff;
   assign o_normal_speed = normal_ff;
   assign o_low_speed_ind = low_ind_ff;
   assign o_overload = ovl_ff;
   assign o_fault = fault_ff;
   assign o_forepump = fore_ff;
   assign o_fan = fan_ff;
   assign o_vent = vent_ff;
endmodule
`default_nettype wire

// [design/pump_sup_pkg.sv]
package pump_sup_pkg;
   // Clock and time base
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_S = 1;
   localparam int TICK_CYC = CLK_HZ * TICK_S;
   localparam int DEB_MS = 10;
   localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
   // Limits
   localparam logic [7:0] TEMP_MAX_C = 8'h3c;
   localparam logic [9:0] P_OVER_W = 10'h0dc;
   localparam logic [7:0] T_OVER_S = 8'h14;
   localparam logic [9:0] P_START1_W = 10'h2bc;
   localparam logic [7:0] T_START1_S = 8'h2d;
   localparam logic [9:0] P_START2_W = 10'h15e;
   localparam logic [7:0] T_START2_S = 8'h87;
   localparam int T_LOW_MIN = 3;
   localparam logic [7:0] T_LOW_S = 8'(T_LOW_MIN * 60);
   // Speed points in percent of nominal
   localparam logic [6:0] F_START = 7'h3c;
   localparam logic [6:0] F_NOM = 7'h64;
   localparam logic [6:0] F_LOW = 7'h46;
   localparam logic [6:0] F_MIN_LOAD = 7'h46;
   // Register map
   localparam logic [7:0] A_VENT_DLY = 8'h00;
   localparam logic [7:0] A_LOAD_KNEE = 8'h04;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_SPEED = 8'h0c;
   localparam logic [7:0] VENT_DLY_RST = 8'h0a;
   localparam logic [9:0] LOAD_KNEE_RST = 10'h096;
   // Status and speed register field positions
   localparam int SB_ARMED = 3;
   localparam int SB_ACK = 4;
   localparam int SB_LOW_REQ = 5;
   localparam int SB_LOW_ACT = 6;
   localparam int SB_DRIVE = 7;
   localparam int SB_OVL = 8;
   localparam int SB_FAULT = 9;
   localparam int SB_FORE = 10;
   localparam int SB_FAN = 11;
   localparam int SB_VENT = 12;
   localparam int SB_NORMAL = 13;
   localparam int SB_RUN_S = 16;
   localparam int SB_ROTOR = 8;
   localparam int SB_POWER = 16;
   typedef enum logic [2:0] {
      S_IDLE, S_ACC, S_SYNC, S_ACCEL, S_RUN, S_FAULT, S_PFAIL
   } run_state_t;
   typedef enum logic [1:0] {OWN_NONE, OWN_PANEL, OWN_REMOTE} low_owner_t;
endpackage

// [test/pump_sup_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module pump_sup_asserts
   import pump_sup_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int DEB_CYCLES = DEB_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_remote_start,
   input wire logic i_interlock_ok,
   input wire logic i_power_good,
   input wire logic i_stator_short,
   input wire logic [7:0] i_pump_temp_c,
   input wire logic i_ctrl_overtemp,
   input wire logic o_drive_en,
   input wire logic o_max_power,
   input wire logic [6:0] o_freq_pct,
   input wire logic o_normal_speed,
   input wire logic o_overload,
   input wire logic o_fault,
   input wire logic o_forepump,
   input wire logic o_fan,
   input wire logic o_vent
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   sequence all_off_s;
      !o_drive_en && !o_forepump && !o_fan;
   endsequence
   sequence stopped_s;
      !o_drive_en && !o_forepump;
   endsequence
   ovl_cuts_a: assert property (o_overload |-> all_off_s)
      else $error("overload with outputs on");
   short_trip_a: assert property (o_drive_en && i_stator_short |-> ##[1:3] o_overload)
      else $error("stator short did not trip");
   temp_trip_a: assert property (o_drive_en && i_pump_temp_c > TEMP_MAX_C |->
      ##[1:3] o_overload)
      else $error("hot pump did not trip");
   ctrl_hot_a: assert property (o_drive_en && i_ctrl_overtemp |-> ##[1:3] o_overload)
      else $error("hot controller did not trip");
   remote_stop_a: assert property ($fell(i_remote_start) && o_drive_en |->
      ##[1:3] stopped_s)
      else $error("remote removal did not stop");
   ilk_stop_a: assert property (!i_interlock_ok && o_drive_en |-> ##[1:3] !o_drive_en)
      else $error("open interlock did not stop");
   pfail_off_a: assert property (!i_power_good && !o_overload |-> ##[1:3] all_off_s)
      else $error("power loss did not stop");
   normal_at_a: assert property ($rose(o_normal_speed) |-> o_drive_en && !o_max_power &&
      (o_freq_pct == F_NOM || o_freq_pct == F_LOW))
      else $error("normal speed off target");
   fault_why_a: assert property (o_fault |-> o_overload && !o_drive_en)
      else $error("fault without overload");
   vent_wait_a: assert property ($fell(o_forepump) |=> !o_vent [*8])
      else $error("vent too early");
   vent_off_a: assert property (o_vent |-> all_off_s)
      else $error("vent while running");
   start_full_a: assert property ($rose(o_drive_en) |->
      o_max_power && o_freq_pct >= F_START)
      else $error("start not at full power");
endmodule
bind vacuum_pump_run_supervisor pump_sup_asserts #(.TICK_CYCLES(TICK_CYCLES),
   .DEB_CYCLES(DEB_CYCLES)) u_chk (.i_clk_sys, .i_sys_rst, .i_remote_start,
   .i_interlock_ok, .i_power_good, .i_stator_short, .i_pump_temp_c, .i_ctrl_overtemp,
   .o_drive_en, .o_max_power, .o_freq_pct, .o_normal_speed, .o_overload, .o_fault,
   .o_forepump, .o_fan, .o_vent);
`default_nettype wire

// [test/pump_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pump_model (
   input wire logic i_clk,
   input wire logic i_drive_en,
   input wire logic [6:0] i_freq_pct,
   input wire logic [9:0] i_load_w,
   output logic [6:0] o_rotor_pct,
   output logic [9:0] o_power_w
);
   logic [6:0] div_ff = 7'h00;
   initial o_rotor_pct = 7'h00;
   // Rotor follows drive; unpowered it coasts slowly, so restarts meet a turning rotor
   always @(posedge i_clk) begin
      div_ff <= div_ff + 7'h01;
      if (i_drive_en) begin
         o_rotor_pct <= i_freq_pct;
      end else if (div_ff == 7'h00 && o_rotor_pct != 7'h00) begin
         o_rotor_pct <= o_rotor_pct - 7'h01;
      end
   end
   assign o_power_w = i_drive_en ? i_load_w : 10'h000;
endmodule
`default_nettype wire

// [test/vacuum_pump_run_supervisor_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module vacuum_pump_run_supervisor_tb import pump_sup_pkg::*;;
   localparam int TK = 20;
   localparam int DB = 4;
   localparam int W_DRV = 0, W_NRM = 1, W_OVL = 2, W_FORE = 3, W_VENT = 4, W_LOW = 5;
   logic i_clk_sys, i_sys_rst, i_hsel, i_hwrite, i_btn_onoff, i_panel_low_sw, i_remote_start;
   logic i_remote_low, i_interlock_ok, i_power_good, i_stator_short, i_ctrl_overtemp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
   logic [1:0] i_htrans;
   logic [2:0] i_hsize;
   logic [7:0] i_pump_temp_c;
   logic [9:0] i_power_w, load_w;
   logic [6:0] i_rotor_pct, o_freq_pct;
   logic o_hreadyout, o_hresp, o_drive_en, o_max_power, o_normal_speed, o_low_speed_ind;
   logic o_overload, o_fault, o_forepump, o_fan, o_vent;
   int n_mismatch = 0;
   int checked = 0;
   vacuum_pump_run_supervisor #(.TICK_CYCLES(TK), .DEB_CYCLES(DB)) dut (.i_clk_sys,
      .i_sys_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
      .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_btn_onoff,
      .i_panel_low_sw, .i_remote_start, .i_remote_low, .i_interlock_ok, .i_power_good,
      .i_stator_short, .i_pump_temp_c, .i_ctrl_overtemp, .i_power_w, .i_rotor_pct,
      .o_drive_en, .o_max_power, .o_freq_pct, .o_normal_speed, .o_low_speed_ind,
      .o_overload, .o_fault, .o_forepump, .o_fan, .o_vent);
   pump_model pump (.i_clk(i_clk_sys), .i_drive_en(o_drive_en), .i_freq_pct(o_freq_pct),
      .i_load_w(load_w), .o_rotor_pct(i_rotor_pct), .o_power_w(i_power_w));
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic chb(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chv(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         W_DRV: return o_drive_en;
         W_NRM: return o_normal_speed;
         W_OVL: return o_overload;
         W_FORE: return o_forepump;
         W_VENT: return o_vent;
         default: return o_low_speed_ind;
      endcase
   endfunction
   // Bounded wait; the compare after it judges the outcome
   task automatic wt(input int s, input logic v, input int ticks);
      for (int i = 0; i < ticks * TK && sig(s) !== v; i++) @(posedge i_clk_sys);
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] r);
      i_hsel <= 1'b1;
      i_htrans <= 2'b10;
      i_hwrite <= wr;
      i_haddr <= {24'h000000, a};
      @(posedge i_clk_sys);
      while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
      i_hsel <= 1'b0;
      i_htrans <= 2'b00;
      i_hwdata <= wd;
      @(posedge i_clk_sys);
      while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
      r = o_hrdata;
   endtask
   task automatic press();
      i_btn_onoff <= 1'b1;
      cyc(DB + 3);
      i_btn_onoff <= 1'b0;
      cyc(DB + 3);
   endtask
   task automatic t_regs();
      ahb(1'b0, A_STATUS, 32'h0, rd);
      chv("status", 32'h0, rd);
      ahb(1'b0, A_VENT_DLY, 32'h0, rd);
      chv("vent_dly", {24'h000000, VENT_DLY_RST}, rd);
      chb("okay", 1'b0, o_hresp);
      ahb(1'b1, 8'h10, 32'hffffffff, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chv("unmapped", 32'h0, rd);
      $display("test regs done");
   endtask
   task automatic t_start();
      i_btn_onoff <= 1'b1;
      cyc(2);
      i_btn_onoff <= 1'b0;
      cyc(2 * TK);
      chb("glitch", 1'b0, o_forepump);
      press();
      wt(W_DRV, 1'b1, 4);
      chv("start_freq", {25'h0, F_START}, {25'h0, o_freq_pct});
      chb("max_power", 1'b1, o_max_power);
      chb("early_normal", 1'b0, o_normal_speed);
      wt(W_NRM, 1'b1, 50);
      chv("nominal", {25'h0, F_NOM}, {25'h0, o_freq_pct});
      $display("test start done");
   endtask
   task automatic t_restart();
      i_remote_start <= 1'b0;
      wt(W_DRV, 1'b0, 1);
      chb("stop_fore", 1'b0, o_forepump);
      cyc(3 * TK);
      i_remote_start <= 1'b1;
      wt(W_DRV, 1'b1, 4);
      chb("lock", 1'b1, (o_freq_pct - i_rotor_pct) <= 7'h01);
      wt(W_NRM, 1'b1, 10);
      chb("relock_normal", 1'b1, o_normal_speed);
      $display("test restart done");
   endtask
   task automatic t_load();
      ahb(1'b1, A_LOAD_KNEE, 32'h0, rd);
      load_w <= 10'h0c8;
      cyc(35 * TK);
      chv("load_floor", {25'h0, F_MIN_LOAD}, {25'h0, o_freq_pct});
      chb("load_normal", 1'b0, o_normal_speed);
      ahb(1'b1, A_LOAD_KNEE, {22'h0, LOAD_KNEE_RST}, rd);
      load_w <= 10'h064;
      wt(W_NRM, 1'b1, 40);
      cyc(150 * TK);
      load_w <= 10'h0fa;
      cyc(15 * TK);
      load_w <= 10'h064;
      cyc(10 * TK);
      chb("short_excursion", 1'b0, o_overload);
      load_w <= 10'h0fa;
      cyc(19 * TK);
      chb("not_yet", 1'b0, o_overload);
      wt(W_OVL, 1'b1, 4);
      chb("sustained", 1'b1, o_overload);
      chb("ovl_fore", 1'b0, o_forepump);
      chb("ovl_fan", 1'b0, o_fan);
      chb("ovl_fault", 1'b1, o_fault);
      load_w <= 10'h064;
      press();
      cyc(2 * TK);
      chb("one_press", 1'b1, o_overload);
      press();
      wt(W_FORE, 1'b1, 2);
      chb("two_press", 1'b0, o_overload);
      $display("test load done");
   endtask
   task automatic t_protect();
      i_pump_temp_c <= TEMP_MAX_C;
      cyc(2 * TK);
      chb("temp_at_limit", 1'b0, o_overload);
      for (int k = 0; k < 4; k++) begin
         wt(W_DRV, 1'b1, 4);
         i_stator_short <= (k == 0);
         i_pump_temp_c <= (k == 1) ? TEMP_MAX_C + 8'h01 : 8'h19;
         i_ctrl_overtemp <= (k == 2);
         load_w <= (k == 3) ? 10'h2ee : 10'h064;
         wt(W_OVL, 1'b1, 2);
         chb("cause_trip", 1'b1, o_overload);
         i_stator_short <= 1'b0;
         i_pump_temp_c <= 8'h19;
         i_ctrl_overtemp <= 1'b0;
         load_w <= 10'h064;
         press();
         press();
      end
      wt(W_DRV, 1'b1, 4);
      i_interlock_ok <= 1'b0;
      cyc(2 * TK);
      chb("ilk_hold", 1'b0, o_drive_en);
      chb("ilk_fault", 1'b0, o_fault);
      i_interlock_ok <= 1'b1;
      wt(W_DRV, 1'b1, 4);
      chb("ilk_resume", 1'b1, o_drive_en);
      $display("test protect done");
   endtask
   task automatic t_stop();
      wt(W_NRM, 1'b1, 60);
      press();
      chb("stop_drive", 1'b0, o_drive_en);
      cyc(8 * TK);
      chb("vent_early", 1'b0, o_vent);
      wt(W_VENT, 1'b1, 4);
      chb("vent_late", 1'b1, o_vent);
      $display("test stop done");
   endtask
   task automatic t_low();
      i_panel_low_sw <= 1'b1;
      press();
      cyc(166 * TK);
      chb("low_early", 1'b0, o_low_speed_ind);
      wt(W_LOW, 1'b1, 30);
      chb("low_on", 1'b1, o_low_speed_ind);
      i_remote_low <= 1'b1;
      cyc(TK);
      i_remote_low <= 1'b0;
      cyc(32 * TK);
      chv("low_freq", {25'h0, F_LOW}, {25'h0, o_freq_pct});
      chb("low_normal", 1'b1, o_normal_speed);
      chb("low_kept", 1'b1, o_low_speed_ind);
      i_panel_low_sw <= 1'b0;
      i_remote_low <= 1'b1;
      cyc(2);
      i_panel_low_sw <= 1'b1;
      cyc(TK);
      i_panel_low_sw <= 1'b0;
      cyc(2 * TK);
      chb("remote_owns", 1'b1, o_low_speed_ind);
      chv("remote_freq", {25'h0, F_LOW}, {25'h0, o_freq_pct});
      $display("test low done");
   endtask
   task automatic t_pfail();
      i_power_good <= 1'b0;
      cyc(3 * TK);
      chb("pf_fore", 1'b0, o_forepump);
      chb("pf_short_vent", 1'b0, o_vent);
      i_power_good <= 1'b1;
      wt(W_FORE, 1'b1, 2);
      chb("acc_first", 1'b0, o_drive_en);
      wt(W_DRV, 1'b1, 4);
      chb("pump_after", 1'b1, o_drive_en);
      i_power_good <= 1'b0;
      cyc(12 * TK);
      chb("pf_long_vent", 1'b1, o_vent);
      $display("test pfail done");
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      {i_sys_rst, i_remote_start, i_interlock_ok, i_power_good} = 4'hf;
      {i_hsel, i_hwrite, i_btn_onoff, i_panel_low_sw, i_remote_low} = 5'h00;
      {i_stator_short, i_ctrl_overtemp, i_htrans, i_hsize} = 7'h02;
      {i_haddr, i_hwdata} = 64'h0;
      i_pump_temp_c = 8'h19;
      load_w = 10'h064;
      cyc(10);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      t_regs();
      t_start();
      t_restart();
      t_load();
      t_protect();
      t_stop();
      t_low();
      t_pfail();
      wrap_up();
   end
   initial begin
      cyc(60000);
      n_mismatch++;
      $display("unexpected watchdog: expected end seen timeout");
      wrap_up();
   end
endmodule
`default_nettype wire
